// *** design/sasc_top.v ***
// conversion control, scan sequencer and serial readout of the converter
`timescale 1ns/1ns
`include "sasc_regs.vh"
module sasc_top (
    input wire I_CORE_CLK,
    input wire I_RSTN,
    input wire I_POWER_DOWN_N,
    input wire I_CS_N,
    input wire I_SCK,
    input wire I_SCAN,
    input wire I_LOW_POWER_SELECT,
    input wire I_GAIN_BIT2_OR_BYPASS,
    input wire I_GAIN_BIT1,
    input wire I_GAIN_BIT0,
    input wire I_CHAN_SEL_BIT2,
    input wire I_CHAN_SEL_BIT1,
    input wire I_CHAN_SEL_BIT0,
    input wire I_COMMON_INPUT_FLOATING,
    input wire I_GAIN_AMPLIFIER_BYPASS,
    input wire I_CMP_KEEP,
    output wire O_BUSY,
    output wire O_SDO,
    output wire O_SDO_OE,
    output wire [`SASC_TAG_W-1:0] O_CHAN_ADDR,
    output wire [`SASC_TAG_W-1:0] O_GAIN_CODE,
    output wire [`SASC_DATA_W-1:0] O_DAC_CODE,
    output wire O_TRACK,
    output wire O_CORE_AWAKE,
    output wire O_ANALOG_POWER_ON
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SETTLE = 2'h1;
    localparam [1:0] ST_STEP = 2'h2;
    localparam [1:0] ST_PUSH = 2'h3;
    localparam integer STEP_CYC_I = `SASC_STEP_CYC;
    localparam integer SETTLE_CYC_I = `SASC_SETTLE_CYC;
    localparam integer WORD_BITS_I = `SASC_WORD_W;
    localparam [`SASC_CNT_W-1:0] STEP_CYC = STEP_CYC_I[`SASC_CNT_W-1:0];
    localparam [`SASC_CNT_W-1:0] SETTLE_CYC = SETTLE_CYC_I[`SASC_CNT_W-1:0];
    localparam [`SASC_CNT_W-1:0] CNT_ONE = 4'h1;
    localparam [`SASC_CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam [`SASC_BITCNT_W-1:0] WORD_BITS = WORD_BITS_I[`SASC_BITCNT_W-1:0];
    localparam [`SASC_BITCNT_W-1:0] BIT_ONE = 5'h01;
    wire [`SASC_PIN_W-1:0] pins_raw;
    wire [`SASC_PIN_W-1:0] pins;
    wire pd_n, cs_n, sck, scan, low_power_select, bipolar, bypass;
    wire [`SASC_TAG_W-1:0] gain_pins;
    wire [`SASC_TAG_W-1:0] chan_pins;
    reg cs_prev_q, sck_prev_q, scan_prev_q;
    wire cs_fall, cs_rise, sck_rise, scan_rise;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg busy_q, busy_d, push_q, push_d, low_cons_q, low_cons_d, start_flush;
    reg [`SASC_CNT_W-1:0] cnt_q;
    reg [`SASC_CNT_W-1:0] cnt_d;
    reg [`SASC_DATA_W-1:0] dac_q;
    reg [`SASC_DATA_W-1:0] dac_d;
    reg [`SASC_DATA_W-1:0] mask_q;
    reg [`SASC_DATA_W-1:0] mask_d;
    reg [`SASC_WORD_W-1:0] word_q;
    reg [`SASC_WORD_W-1:0] word_d;
    reg [`SASC_DATA_W-1:0] trial_res;
    reg [`SASC_DATA_W-1:0] coded;
    reg [`SASC_TAG_W-1:0] chan_q, gain_q, conv_chan_q, conv_gain_q, seq_q;
    wire fifo_in_ready, fifo_out_valid;
    wire [`SASC_WORD_W-1:0] fifo_out_data;
    reg loaded_q, loaded_d, pop;
    reg [`SASC_WORD_W-1:0] shreg_q;
    reg [`SASC_WORD_W-1:0] shreg_d;
    reg [`SASC_BITCNT_W-1:0] left_q;
    reg [`SASC_BITCNT_W-1:0] left_d;
    reg sdo_q, sdo_oe_q, track_q, apwr_q;
    assign pins_raw = {I_POWER_DOWN_N, I_CS_N, I_SCK, I_SCAN, I_LOW_POWER_SELECT,
                       I_GAIN_BIT2_OR_BYPASS, I_GAIN_BIT1, I_GAIN_BIT0,
                       I_CHAN_SEL_BIT2, I_CHAN_SEL_BIT1, I_CHAN_SEL_BIT0,
                       I_COMMON_INPUT_FLOATING, I_GAIN_AMPLIFIER_BYPASS};
    sasc_sync #(.W(`SASC_PIN_W)) u_sync (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RSTN),
        .i_pin(pins_raw),
        .o_level(pins)
    );
    assign pd_n = pins[`SASC_PIN_PD];
    assign cs_n = pins[`SASC_PIN_CS];
    assign sck = pins[`SASC_PIN_SCK];
    assign scan = pins[`SASC_PIN_SCAN];
    assign low_power_select = pins[`SASC_PIN_LPM];
    assign bipolar = pins[`SASC_PIN_BIPOLAR];
    assign bypass = pins[`SASC_PIN_BYPASS];
    assign gain_pins = pins[`SASC_PIN_G2:`SASC_PIN_G0];
    assign chan_pins = pins[`SASC_PIN_S2:`SASC_PIN_S0];
    // edge finders on the synchronised levels
    assign cs_fall = cs_prev_q && !cs_n;
    assign cs_rise = !cs_prev_q && cs_n;
    assign sck_rise = !sck_prev_q && sck;
    assign scan_rise = !scan_prev_q && scan;
    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cs_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
            scan_prev_q <= 1'b0;
        end else begin
            cs_prev_q <= cs_n;
            sck_prev_q <= sck;
            scan_prev_q <= scan;
        end
    end
    // channel and gain capture, scan sequencer
    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            chan_q <= `SASC_CHAN_ZERO;
            gain_q <= `SASC_GAIN_RST;
            seq_q <= `SASC_CHAN_ZERO;
        end else begin
            if (scan_rise) begin
                seq_q <= `SASC_CHAN_ZERO;
            end
            if (cs_rise) begin
                gain_q <= gain_pins;
                if (scan) begin
                    chan_q <= scan_rise ? `SASC_CHAN_ZERO : seq_q;
                    seq_q <= (scan_rise ? `SASC_CHAN_ZERO : seq_q) + 3'h1;
                end else begin
                    chan_q <= chan_pins;
                end
            end
        end
    end
    // successive approximation sequencer on the core clock
    always @* begin
        state_d = state_q;
        busy_d = busy_q;
        cnt_d = cnt_q;
        dac_d = dac_q;
        mask_d = mask_q;
        word_d = word_q;
        push_d = push_q;
        low_cons_d = low_cons_q;
        start_flush = 1'b0;
        trial_res = I_CMP_KEEP ? dac_q : (dac_q & ~mask_q);
        coded = bipolar ? {~trial_res[`SASC_DATA_W-1], trial_res[`SASC_DATA_W-2:0]} :
                trial_res;
        if (cs_rise) begin
            low_cons_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (cs_fall) begin
                    busy_d = 1'b1;
                    low_cons_d = 1'b0;
                    start_flush = 1'b1;
                    dac_d = `SASC_MSB_MASK;
                    mask_d = `SASC_MSB_MASK;
                    // bypassed amplifier skips the settle wait
                    if (bypass) begin
                        cnt_d = STEP_CYC;
                        state_d = ST_STEP;
                    end else begin
                        cnt_d = SETTLE_CYC;
                        state_d = ST_SETTLE;
                    end
                end
            end
            ST_SETTLE: begin
                if (cnt_q == CNT_ONE) begin
                    cnt_d = STEP_CYC;
                    state_d = ST_STEP;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_STEP: begin
                if (cnt_q == CNT_ONE) begin
                    cnt_d = STEP_CYC;
                    if (mask_q[0]) begin
                        word_d = {coded, conv_chan_q, conv_gain_q};
                        push_d = 1'b1;
                        state_d = ST_PUSH;
                    end else begin
                        dac_d = trial_res | (mask_q >> 1);
                        mask_d = mask_q >> 1;
                    end
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    push_d = 1'b0;
                    busy_d = 1'b0;
                    low_cons_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                busy_d = 1'b0;
                push_d = 1'b0;
            end
        endcase
        if (!pd_n) begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
            push_d = 1'b0;
            low_cons_d = 1'b1;
        end
    end
    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            cnt_q <= CNT_ZERO;
            dac_q <= {`SASC_DATA_W{1'b0}};
            mask_q <= {`SASC_DATA_W{1'b0}};
            word_q <= {`SASC_WORD_W{1'b0}};
            push_q <= 1'b0;
            low_cons_q <= 1'b1;
            conv_chan_q <= `SASC_CHAN_ZERO;
            conv_gain_q <= `SASC_GAIN_RST;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            cnt_q <= cnt_d;
            dac_q <= dac_d;
            mask_q <= mask_d;
            word_q <= word_d;
            push_q <= push_d;
            low_cons_q <= low_cons_d;
            if (start_flush) begin
                conv_chan_q <= chan_q;
                conv_gain_q <= gain_q;
            end
        end
    end
    sasc_fifo #(.W(`SASC_WORD_W), .DEPTH(`SASC_FIFO_DEPTH), .AW(`SASC_FIFO_AW)) u_fifo (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RSTN),
        .i_flush(start_flush),
        .i_in_valid(push_q),
        .o_in_ready(fifo_in_ready),
        .i_in_data(word_q),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_out_data)
    );
    // serial shifter, fed from the fifo
    always @* begin
        loaded_d = loaded_q;
        shreg_d = shreg_q;
        left_d = left_q;
        pop = 1'b0;
        if (start_flush || !pd_n) begin
            loaded_d = 1'b0;
            shreg_d = {`SASC_WORD_W{1'b0}};
            left_d = {`SASC_BITCNT_W{1'b0}};
        end else if (!loaded_q) begin
            if (fifo_out_valid) begin
                pop = 1'b1;
                loaded_d = 1'b1;
                shreg_d = fifo_out_data;
                left_d = WORD_BITS;
            end
        end else if (sck_rise && !cs_n && !busy_q) begin
            shreg_d = {shreg_q[`SASC_WORD_W-2:0], 1'b0};
            left_d = left_q - BIT_ONE;
            if (left_q == BIT_ONE) begin
                loaded_d = 1'b0;
            end
        end
    end
    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            loaded_q <= 1'b0;
            shreg_q <= {`SASC_WORD_W{1'b0}};
            left_q <= {`SASC_BITCNT_W{1'b0}};
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            track_q <= 1'b0;
            apwr_q <= 1'b0;
        end else begin
            loaded_q <= loaded_d;
            shreg_q <= shreg_d;
            left_q <= left_d;
            sdo_q <= shreg_d[`SASC_WORD_W-1];
            sdo_oe_q <= !cs_n && pd_n;
            track_q <= cs_n && pd_n && !busy_d;
            // low-power mode powers the analog section only for acquisition and conversion
            if (!pd_n) begin
                apwr_q <= 1'b0;
            end else if (low_power_select) begin
                apwr_q <= cs_n || busy_d;
            end else begin
                apwr_q <= 1'b1;
            end
        end
    end
    assign O_BUSY = busy_q;
    assign O_SDO = sdo_q;
    assign O_SDO_OE = sdo_oe_q;
    assign O_CHAN_ADDR = chan_q;
    assign O_GAIN_CODE = gain_q;
    assign O_DAC_CODE = dac_q;
    assign O_TRACK = track_q;
    assign O_CORE_AWAKE = !low_cons_q;
    assign O_ANALOG_POWER_ON = apwr_q;
endmodule // sasc_top

// *** design/sasc_regs.vh ***
// constants shared by the serial converter control block
`ifndef SASC_REGS_VH
`define SASC_REGS_VH
`define SASC_DATA_W 14
`define SASC_TAG_W 3
`define SASC_WORD_W 20
`define SASC_BITCNT_W 5
`define SASC_FIFO_DEPTH 16
`define SASC_FIFO_AW 4
`define SASC_PIN_W 13
`define SASC_CLK_PERIOD_NS 100
`define SASC_STEP_TIME_NS 100
`define SASC_PGA_SETTLE_NS 400
`define SASC_STEP_CYC ((`SASC_STEP_TIME_NS + `SASC_CLK_PERIOD_NS - 1) / `SASC_CLK_PERIOD_NS)
`define SASC_SETTLE_CYC ((`SASC_PGA_SETTLE_NS + `SASC_CLK_PERIOD_NS - 1) / `SASC_CLK_PERIOD_NS)
`define SASC_CNT_W 4
`define SASC_MSB_MASK 14'h2000
`define SASC_CHAN_ZERO 3'h0
`define SASC_GAIN_RST 3'h0
`define SASC_PIN_RST 13'h0000
`define SASC_PIN_PD 12
`define SASC_PIN_CS 11
`define SASC_PIN_SCK 10
`define SASC_PIN_SCAN 9
`define SASC_PIN_LPM 8
`define SASC_PIN_G2 7
`define SASC_PIN_G0 5
`define SASC_PIN_S2 4
`define SASC_PIN_S0 2
`define SASC_PIN_BIPOLAR 1
`define SASC_PIN_BYPASS 0
`endif

// *** design/sasc_sync.v ***
// three-stage pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ns
module sasc_sync #(
    parameter W = 1
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [W-1:0] i_pin,
    output wire [W-1:0] o_level
);
    reg [W-1:0] ff1_q;
    reg [W-1:0] ff2_q;
    reg [W-1:0] ff3_q;
    reg [W-1:0] out_q;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ff1_q[g] <= 1'b0;
                    ff2_q[g] <= 1'b0;
                    ff3_q[g] <= 1'b0;
                    out_q[g] <= 1'b0;
                end else begin
                    ff1_q[g] <= i_pin[g];
                    ff2_q[g] <= ff1_q[g];
                    ff3_q[g] <= ff2_q[g];
                    if (ff2_q[g] == ff3_q[g]) begin
                        out_q[g] <= ff3_q[g];
                    end
                end
            end
        end
    endgenerate
    assign o_level = out_q;
endmodule // sasc_sync

// *** design/sasc_fifo.v ***
// result word fifo with valid and ready on both sides
`timescale 1ns/1ns
module sasc_fifo #(
    parameter W = 20,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_flush,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [W-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [W-1:0] o_out_data
);
    reg [W-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire empty;
    wire full;
    wire push;
    wire pop;
    assign empty = (wr_q == rd_q);
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign push = i_in_valid && !full;
    assign pop = i_out_ready && !empty;
    assign o_out_data = mem_q[rd_q[AW-1:0]];
    always @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else if (i_flush) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // sasc_fifo

// *** dv/sasc_top_chk.sv ***
// assertion checker for the converter control block
`timescale 1ns/1ns
`include "sasc_regs.vh"
module sasc_top_chk (
    input wire I_CORE_CLK,
    input wire I_RSTN,
    input wire I_POWER_DOWN_N,
    input wire I_CS_N,
    input wire I_SCAN,
    input wire I_LOW_POWER_SELECT,
    input wire O_BUSY,
    input wire O_SDO,
    input wire O_SDO_OE,
    input wire [`SASC_TAG_W-1:0] O_CHAN_ADDR,
    input wire [`SASC_TAG_W-1:0] O_GAIN_CODE,
    input wire O_TRACK,
    input wire O_CORE_AWAKE,
    input wire O_ANALOG_POWER_ON
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RSTN);
    property p_oe_off;
        I_CS_N [*8] |-> !O_SDO_OE;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver on with cs high");
    property p_oe_on;
        (!I_CS_N && I_POWER_DOWN_N) [*8] |-> O_SDO_OE;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("driver off with cs low");
    property p_pd;
        (!I_POWER_DOWN_N) [*8] |-> !O_BUSY && !O_SDO_OE && !O_ANALOG_POWER_ON;
    endproperty
    a_pd: assert property (p_pd) else $error("activity in power-down");
    property p_start;
        $fell(I_CS_N) && !O_BUSY && I_POWER_DOWN_N |-> ##[3:7] $rose(O_BUSY);
    endproperty
    a_start: assert property (p_start) else $error("busy late after cs fall");
    // busy length bounds: one step per data bit plus push, settle wait on top
    localparam int BUSY_MIN = `SASC_DATA_W * `SASC_STEP_CYC + 1;
    localparam int BUSY_MAX = BUSY_MIN + `SASC_SETTLE_CYC;
    reg [7:0] busy_run_q;
    always @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            busy_run_q <= 8'h00;
        end else if (O_BUSY) begin
            busy_run_q <= busy_run_q + 8'h01;
        end else begin
            busy_run_q <= 8'h00;
        end
    end
    property p_busy_len;
        @(posedge I_CORE_CLK) disable iff (!I_RSTN || !I_POWER_DOWN_N)
        $fell(O_BUSY) |-> busy_run_q >= BUSY_MIN && busy_run_q <= BUSY_MAX;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length off");
    property p_core;
        $fell(O_BUSY) && I_POWER_DOWN_N |-> ##[0:2] !O_CORE_AWAKE;
    endproperty
    a_core: assert property (p_core) else $error("core awake after end");
    property p_lpm;
        (I_LOW_POWER_SELECT && !I_CS_N && !O_BUSY) [*8] |-> !O_ANALOG_POWER_ON;
    endproperty
    a_lpm: assert property (p_lpm) else $error("analog on between conversions");
    property p_busy_pw;
        @(posedge I_CORE_CLK) disable iff (!I_RSTN || !I_POWER_DOWN_N)
        O_BUSY && $past(O_BUSY) |-> O_ANALOG_POWER_ON && !O_TRACK;
    endproperty
    a_busy_pw: assert property (p_busy_pw) else $error("unpowered while busy");
    property p_tags;
        O_BUSY |-> $stable(O_CHAN_ADDR) && $stable(O_GAIN_CODE);
    endproperty
    a_tags: assert property (p_tags) else $error("tags moved while busy");
    property p_sdo_busy;
        O_BUSY && $past(O_BUSY) |-> $stable(O_SDO);
    endproperty
    a_sdo_busy: assert property (p_sdo_busy) else $error("data moved while busy");
    c_done: cover property ($fell(O_BUSY));
    c_scan: cover property (I_SCAN && $rose(I_CS_N));
    c_abort: cover property (!I_POWER_DOWN_N && O_BUSY);
endmodule // sasc_top_chk
bind sasc_top sasc_top_chk u_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_POWER_DOWN_N(I_POWER_DOWN_N),
    .I_CS_N(I_CS_N), .I_SCAN(I_SCAN), .I_LOW_POWER_SELECT(I_LOW_POWER_SELECT),
    .O_BUSY(O_BUSY), .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE), .O_CHAN_ADDR(O_CHAN_ADDR),
    .O_GAIN_CODE(O_GAIN_CODE), .O_TRACK(O_TRACK), .O_CORE_AWAKE(O_CORE_AWAKE),
    .O_ANALOG_POWER_ON(O_ANALOG_POWER_ON)
);

// *** dv/sasc_host.sv ***
// host model: chip select, serial clock, channel and gain pins
`timescale 1ns/1ns
module sasc_host (
    input wire i_clk,
    input wire i_busy,
    input wire i_sdo,
    output reg o_cs_n,
    output reg o_sck,
    output reg [2:0] o_chan,
    output reg [2:0] o_gain,
    output reg [19:0] o_word,
    output reg o_word_valid
);
    initial begin
        o_cs_n = 1'b0;
        o_sck = 1'b0;
        o_chan = 3'h0;
        o_gain = 3'h0;
        o_word = 20'h0;
        o_word_valid = 1'b0;
    end
    task automatic conv(input [2:0] c, input [2:0] g, input bit abort);
        int n;
        int i;
        @(posedge i_clk);
        o_chan <= c;
        o_gain <= g;
        repeat (2) @(posedge i_clk);
        o_cs_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_chan <= ~c;
        o_gain <= ~g;
        repeat (8) @(posedge i_clk);
        o_cs_n <= 1'b0;
        n = 0;
        while (i_busy !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        if (abort) return;
        n = 0;
        while (i_busy !== 1'b0 && n < 60) begin
            @(posedge i_clk);
            n++;
        end
        repeat (4) @(posedge i_clk);
        for (i = 19; i >= 0; i--) begin
            o_word[i] <= i_sdo;
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
        o_word_valid <= 1'b1;
        @(posedge i_clk);
        o_word_valid <= 1'b0;
    endtask
endmodule // sasc_host

// *** dv/sasc_top_tb.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ns
module sasc_top_tb;
    reg clk, rstn, pd_n, scan, low_power_select, flt, byp, keep;
    reg [15:0] lfsr;
    wire cs_n, sck, word_valid, busy, sdo, sdo_oe, core_awake, apwr;
    wire [2:0] chan, gain;
    wire [19:0] word;
    wire [2:0] chan_addr, gain_code;
    wire [13:0] dac_code;
    logic [19:0] e;
    logic [19:0] exp_q[$];
    int bad_count;
    int n_compared;
    int k;
    sasc_top u_sasc_top (
        .I_CORE_CLK(clk), .I_RSTN(rstn), .I_POWER_DOWN_N(pd_n), .I_CS_N(cs_n), .I_SCK(sck),
        .I_SCAN(scan), .I_LOW_POWER_SELECT(low_power_select), .I_GAIN_BIT2_OR_BYPASS(gain[2]),
        .I_GAIN_BIT1(gain[1]), .I_GAIN_BIT0(gain[0]), .I_CHAN_SEL_BIT2(chan[2]),
        .I_CHAN_SEL_BIT1(chan[1]), .I_CHAN_SEL_BIT0(chan[0]), .I_COMMON_INPUT_FLOATING(flt),
        .I_GAIN_AMPLIFIER_BYPASS(byp), .I_CMP_KEEP(keep), .O_BUSY(busy), .O_SDO(sdo),
        .O_SDO_OE(sdo_oe), .O_CHAN_ADDR(chan_addr), .O_GAIN_CODE(gain_code),
        .O_DAC_CODE(dac_code), .O_TRACK(),
        .O_CORE_AWAKE(core_awake), .O_ANALOG_POWER_ON(apwr)
    );
    sasc_host u_sasc_host (
        .i_clk(clk), .i_busy(busy), .i_sdo(sdo_oe ? sdo : 1'bz), .o_cs_n(cs_n), .o_sck(sck),
        .o_chan(chan), .o_gain(gain), .o_word(word), .o_word_valid(word_valid)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic [15:0] lfsr_next(input [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // note the expected word, then let the host run one conversion
    task automatic one_conv(input [2:0] sch, input bit use_scan);
        logic [13:0] d;
        lfsr = lfsr_next(lfsr);
        @(posedge clk);
        keep <= lfsr[9];
        d = lfsr[9] ? 14'h3fff : 14'h0000;
        d[13] = d[13] ^ flt;
        exp_q.push_back({d, use_scan ? sch : lfsr[2:0], lfsr[5:3]});
        u_sasc_host.conv(lfsr[2:0], lfsr[5:3], 1'b0);
    endtask
    always @(posedge clk) begin
        if (word_valid === 1'b1) begin
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check("word", word, e);
                check("chan_addr", {17'h0, chan_addr}, {17'h0, e[5:3]});
                check("gain_code", {17'h0, gain_code}, {17'h0, e[2:0]});
                check("dac_code", {6'h0, dac_code}, {6'h0, (e[18] ? 14'h3fff : 14'h0001)});
            end else begin
                check("word", word, 20'hxxxxx);
            end
        end
    end
    initial begin
        #3000000;
        bad_count++;
        print_verdict;
    end
    initial begin
        rstn = 1'b0;
        pd_n = 1'b1;
        scan = 1'b0;
        low_power_select = 1'b0;
        flt = 1'b0;
        byp = 1'b0;
        keep = 1'b0;
        lfsr = 16'h5181;
        bad_count = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        for (k = 0; k < 4; k++) one_conv(3'h0, 1'b0);
        u_sasc_host.conv(3'h5, 3'h2, 1'b1);
        pd_n <= 1'b0;
        repeat (12) @(posedge clk);
        check("busy", {19'h0, busy}, 20'h0);
        check("sdo_oe", {19'h0, sdo_oe}, 20'h0);
        check("apwr", {19'h0, apwr}, 20'h0);
        pd_n <= 1'b1;
        repeat (8) @(posedge clk);
        one_conv(3'h0, 1'b0);
        scan <= 1'b1;
        repeat (8) @(posedge clk);
        for (k = 0; k < 9; k++) one_conv(k[2:0], 1'b1);
        scan <= 1'b0;
        rstn <= 1'b0;
        flt <= 1'b1;
        byp <= 1'b1;
        low_power_select <= 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        for (k = 0; k < 6; k++) one_conv(3'h0, 1'b0);
        repeat (12) @(posedge clk);
        check("apwr", {19'h0, apwr}, 20'h0);
        check("awake", {19'h0, core_awake}, 20'h0);
        check("pending", 20'(exp_q.size()), 20'h0);
        print_verdict;
    end
endmodule // sasc_top_tb
